// ### digital_io_command_port.sv
// Functional notes
// - 8-bit output port plus 64 configurable points
// - large variants add 8 further outputs
// - set/clear bit touches only output n
// - conditional bit: nonzero sets, zero clears
// - word write loads port, bit0 is output 1
// - word bit 1 on, 0 off
// - single query returns level, inputs 1..96
// - group query reports all inputs
// - hold until input high, negated until low
// - direction per group of eight, 1 output
`timescale 1ns/1ps
module digital_io_command_port (
  // clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // command port
  input wire logic CMD_VALID,
  input wire dio_pkg::cmd_t CMD_OP,
  input wire logic [6:0] CMD_NUM,
  input wire logic CMD_NEG,
  input wire logic [31:0] CMD_ARG,
  output logic CMD_READY,
  output logic RSP_VALID,
  output logic RSP_BIT,
  output logic [95:0] RSP_GROUP,
  // pins
  input wire logic [95:0] IN_PINS,
  output logic [7:0] OUT_PORT,
  output logic [7:0] OUT_EXTRA,
  output logic [63:0] EXT_OUT,
  output logic [63:0] EXT_OE
);
  typedef struct packed {
    logic [95:0] sync1;
    logic [95:0] sync2;
    logic [7:0] outp;
    logic [7:0] outx;
    logic [63:0] ext;
    logic [7:0] dir;
    logic [63:0] oe;
    logic holding;
    logic [6:0] hold_num;
    logic hold_neg;
    logic ready;
    logic rsp_valid;
    logic rsp_bit;
    logic [95:0] rsp_group;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  logic [95:0] level;

  // output n numbers: 1..8 port, 9..16 extra, 17..80 extended
  function automatic logic in_range(input logic [6:0] n, input int lo, input int hi);
    in_range = (int'(n) >= lo) && (int'(n) <= hi);
  endfunction : in_range

  // input n is 1-based; out of range reads low
  function automatic logic pick(input logic [95:0] v, input logic [6:0] n);
    pick = in_range(n, 1, dio_pkg::IN_W) ? v[7'(n - 7'd1)] : 1'b0;
  endfunction : pick

  // extended points configured as outputs read back the driven value
  genvar g;
  generate
    for (g = 0; g < dio_pkg::NGRP; g++) begin : gl
      assign level[16 + g*8 +: 8] = st_ff.dir[g] ? st_ff.ext[g*8 +: 8]
                                                  : st_ff.sync2[16 + g*8 +: 8];
    end
  endgenerate
  assign level[15:0] = st_ff.sync2[15:0];
  assign level[95:80] = st_ff.sync2[95:80];

  always_comb begin
    logic v;
    logic [6:0] idx;
    v = 1'b0;
    idx = 7'(CMD_NUM - 7'd1);
    nxt_st = st_ff;
    nxt_st.sync1 = IN_PINS;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.rsp_valid = 1'b0;
    for (int k = 0; k < dio_pkg::NGRP; k++) begin
      nxt_st.oe[k*8 +: 8] = {8{st_ff.dir[k]}};
    end
    if (st_ff.holding) begin
      if (pick(level, st_ff.hold_num) != st_ff.hold_neg) begin
        nxt_st.holding = 1'b0;
        nxt_st.ready = 1'b1;
        nxt_st.rsp_valid = 1'b1;
      end
    end else if (CMD_VALID) begin
      v = (CMD_OP == dio_pkg::CMD_SET_BIT) ? 1'b1 :
          (CMD_OP == dio_pkg::CMD_CLR_BIT) ? 1'b0 : (CMD_ARG != 32'h0);
      unique case (CMD_OP)
        dio_pkg::CMD_SET_BIT, dio_pkg::CMD_CLR_BIT, dio_pkg::CMD_WR_BIT: begin
          if (in_range(CMD_NUM, 1, 8)) begin
            nxt_st.outp[idx[2:0]] = v;
          end else if (in_range(CMD_NUM, 9, 16)) begin
            nxt_st.outx[idx[2:0]] = v;
          end else if (in_range(CMD_NUM, dio_pkg::EXT_FIRST, 80)) begin
            nxt_st.ext[6'(idx - 7'd16)] = v;
          end
          nxt_st.rsp_valid = 1'b1;
        end
        dio_pkg::CMD_WR_WORD: begin
          nxt_st.outp = CMD_ARG[7:0];
          nxt_st.rsp_valid = 1'b1;
        end
        dio_pkg::CMD_SET_DIR: begin
          nxt_st.dir = CMD_ARG[7:0];
          nxt_st.rsp_valid = 1'b1;
        end
        dio_pkg::CMD_RD_GROUP: begin
          nxt_st.rsp_group = level;
          nxt_st.rsp_valid = 1'b1;
        end
        dio_pkg::CMD_RD_BIT: begin
          nxt_st.rsp_bit = pick(level, CMD_NUM);
          nxt_st.rsp_valid = 1'b1;
        end
        dio_pkg::CMD_HOLD: begin
          nxt_st.holding = 1'b1;
          nxt_st.hold_num = CMD_NUM;
          nxt_st.hold_neg = CMD_NEG;
          nxt_st.ready = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_ff <= '{sync1: dio_pkg::GRP_RST, sync2: dio_pkg::GRP_RST,
                 outp: dio_pkg::OUT_RST, outx: dio_pkg::OUT_RST,
                 ext: dio_pkg::EXT_RST, dir: dio_pkg::DIR_RST, oe: dio_pkg::EXT_RST,
                 holding: 1'b0, hold_num: 7'h00, hold_neg: 1'b0, ready: 1'b1,
                 rsp_valid: 1'b0, rsp_bit: 1'b0,
                 rsp_group: dio_pkg::GRP_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign CMD_READY = st_ff.ready;
  assign RSP_VALID = st_ff.rsp_valid;
  assign RSP_BIT = st_ff.rsp_bit;
  assign RSP_GROUP = st_ff.rsp_group;
  assign OUT_PORT = st_ff.outp;
  assign OUT_EXTRA = st_ff.outx;
  assign EXT_OUT = st_ff.ext;
  assign EXT_OE = st_ff.oe;

  a_word_write: assert property (@(posedge CLK) disable iff (!ARST_N)
    CMD_VALID && CMD_READY && CMD_OP == dio_pkg::CMD_WR_WORD
    |=> OUT_PORT == $past(CMD_ARG[7:0]) && RSP_VALID)
    else $error("word write not loaded");
  a_word_only: assert property (@(posedge CLK) disable iff (!ARST_N)
    CMD_VALID && CMD_READY && CMD_OP == dio_pkg::CMD_WR_WORD
    |=> $stable(OUT_EXTRA) && $stable(EXT_OUT))
    else $error("word write touched other outputs");
  a_set_bit: assert property (@(posedge CLK) disable iff (!ARST_N)
    CMD_VALID && CMD_READY && CMD_OP == dio_pkg::CMD_SET_BIT && CMD_NUM >= 7'd1
    && CMD_NUM <= 7'd8 |=> OUT_PORT == ($past(OUT_PORT) | (8'h01 << ($past(CMD_NUM) - 7'd1))))
    else $error("set bit wrong");
  a_clr_bit: assert property (@(posedge CLK) disable iff (!ARST_N)
    CMD_VALID && CMD_READY && CMD_OP == dio_pkg::CMD_CLR_BIT && CMD_NUM >= 7'd1
    && CMD_NUM <= 7'd8
    |=> OUT_PORT == ($past(OUT_PORT) & ~(8'h01 << ($past(CMD_NUM) - 7'd1))))
    else $error("clear bit wrong");
  a_set_only: assert property (@(posedge CLK) disable iff (!ARST_N)
    CMD_VALID && CMD_READY && CMD_OP inside {dio_pkg::CMD_SET_BIT, dio_pkg::CMD_CLR_BIT}
    && CMD_NUM >= 7'd1 && CMD_NUM <= 7'd8
    |=> $stable(OUT_EXTRA) && $stable(EXT_OUT))
    else $error("bit command touched other outputs");
  a_cond_bit: assert property (@(posedge CLK) disable iff (!ARST_N)
    CMD_VALID && CMD_READY && CMD_OP == dio_pkg::CMD_WR_BIT && CMD_NUM == 7'd1
    |=> OUT_PORT[0] == ($past(CMD_ARG) != 32'h0))
    else $error("conditional bit wrong");
  a_cond_any: assert property (@(posedge CLK) disable iff (!ARST_N)
    CMD_VALID && CMD_READY && CMD_OP == dio_pkg::CMD_WR_BIT && CMD_NUM >= 7'd1
    && CMD_NUM <= 7'd8
    |=> OUT_PORT[3'($past(CMD_NUM) - 7'd1)] == ($past(CMD_ARG) != 32'h0))
    else $error("conditional bit wrong at n");
  a_extra_set: assert property (@(posedge CLK) disable iff (!ARST_N)
    CMD_VALID && CMD_READY && CMD_OP == dio_pkg::CMD_SET_BIT && CMD_NUM == 7'd9
    |=> OUT_EXTRA[0] && $stable(OUT_PORT))
    else $error("extra output not set");
  a_ext_set: assert property (@(posedge CLK) disable iff (!ARST_N)
    CMD_VALID && CMD_READY && CMD_OP == dio_pkg::CMD_SET_BIT && CMD_NUM >= 7'd17
    && CMD_NUM <= 7'd80
    |=> EXT_OUT == ($past(EXT_OUT) | (64'h1 << ($past(CMD_NUM) - 7'd17))))
    else $error("extended output not set");
  a_sync_delay: assert property (@(posedge CLK) disable iff (!ARST_N)
    ##2 st_ff.sync2 == $past(IN_PINS, 2))
    else $error("input not synchronised twice");
  a_dir_load: assert property (@(posedge CLK) disable iff (!ARST_N)
    CMD_VALID && CMD_READY && CMD_OP == dio_pkg::CMD_SET_DIR
    |=> st_ff.dir == $past(CMD_ARG[7:0]) && RSP_VALID)
    else $error("direction not loaded");
  a_dir_oe: assert property (@(posedge CLK) disable iff (!ARST_N)
    CMD_VALID && CMD_READY && CMD_OP == dio_pkg::CMD_SET_DIR
    |=> ##1 EXT_OE[7:0] == {8{$past(CMD_ARG[0], 2)}})
    else $error("direction not applied");
  a_oe_top: assert property (@(posedge CLK) disable iff (!ARST_N)
    EXT_OE[63:56] == {8{$past(st_ff.dir[7])}})
    else $error("top group enable wrong");
  a_hold_stall: assert property (@(posedge CLK) disable iff (!ARST_N)
    CMD_VALID && CMD_READY && CMD_OP == dio_pkg::CMD_HOLD |=> !CMD_READY)
    else $error("hold did not stall");
  a_hold_ready: assert property (@(posedge CLK) disable iff (!ARST_N)
    CMD_READY == !st_ff.holding)
    else $error("ready disagrees with hold");
  a_hold_release: assert property (@(posedge CLK) disable iff (!ARST_N)
    st_ff.holding && pick(level, st_ff.hold_num) != st_ff.hold_neg |=> CMD_READY && RSP_VALID)
    else $error("hold not released");
  a_group_read: assert property (@(posedge CLK) disable iff (!ARST_N)
    CMD_VALID && CMD_READY && CMD_OP == dio_pkg::CMD_RD_GROUP |=> RSP_GROUP == $past(level))
    else $error("group read wrong");
  a_bit_read: assert property (@(posedge CLK) disable iff (!ARST_N)
    CMD_VALID && CMD_READY && CMD_OP == dio_pkg::CMD_RD_BIT
    |=> RSP_BIT == $past(pick(level, CMD_NUM)))
    else $error("bit read wrong");
  a_bit_range: assert property (@(posedge CLK) disable iff (!ARST_N)
    CMD_VALID && CMD_READY && CMD_OP == dio_pkg::CMD_RD_BIT
    && (CMD_NUM == 7'd0 || CMD_NUM > 7'd96)
    |=> !RSP_BIT && RSP_VALID)
    else $error("out of range input not low");
endmodule : digital_io_command_port

// ### dio_pkg.sv
package dio_pkg;
  localparam int OUT_W = 8;
  localparam int XOUT_W = 8;
  localparam int EXT_W = 64;
  localparam int GRP_W = 8;
  localparam int NGRP = 8;
  localparam int IN_W = 96;
  localparam int NUM_W = 7;
  localparam int EXT_FIRST = 17;
  localparam logic [7:0] OUT_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [63:0] EXT_RST = 64'h0;
  localparam logic [95:0] GRP_RST = 96'h0;
  typedef enum logic [2:0] {
    CMD_SET_BIT, CMD_CLR_BIT, CMD_WR_BIT, CMD_WR_WORD,
    CMD_SET_DIR, CMD_RD_GROUP, CMD_RD_BIT, CMD_HOLD
  } cmd_t;
endpackage : dio_pkg

// ### ext_world.sv
`timescale 1ns/1ps
module ext_world (
  // switch levels chosen by the bench
  input wire logic [95:0] sw,
  // device side
  input wire logic [63:0] ext_out,
  input wire logic [63:0] ext_oe,
  output logic [95:0] pins
);
  // an extended point that the device drives shows its own level on the wire
  always_comb begin
    pins = sw;
    for (int k = 0; k < 64; k++)
      if (ext_oe[k])
        pins[16+k] = ext_out[k];
  end
endmodule : ext_world

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk = 0;
  logic arst_n = 0;
  logic vld = 0;
  logic neg = 0;
  dio_pkg::cmd_t op;
  logic [6:0] num;
  logic [31:0] arg;
  logic rdy, rv, rb, eb;
  logic [95:0] rg, pins, sw, eg;
  logic [7:0] outp, oute, eo, m;
  logic [63:0] xo, xe, x, ee;
  int p;
  logic [104:0] q[$];
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  initial forever #50 clk = ~clk;
  digital_io_command_port dut_u (.CLK(clk), .ARST_N(arst_n), .CMD_VALID(vld), .CMD_OP(op),
    .CMD_NUM(num), .CMD_NEG(neg), .CMD_ARG(arg), .CMD_READY(rdy), .RSP_VALID(rv),
    .RSP_BIT(rb), .RSP_GROUP(rg), .IN_PINS(pins), .OUT_PORT(outp), .OUT_EXTRA(oute),
    .EXT_OUT(xo), .EXT_OE(xe));
  ext_world ew_u (.sw(sw), .ext_out(xo), .ext_oe(xe), .pins(pins));
  task check(logic [104:0] s, logic [104:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  task results;
    $display("errors=%0d checks=%0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  // drive one command, hold it until taken, and note the state expected once it completes
  task cmd(dio_pkg::cmd_t o, int n, logic g, logic [31:0] a);
    logic b;
    op = o;
    num = n[6:0];
    neg = g;
    arg = a;
    vld = 1;
    while (rdy !== 1'b1) @(negedge clk);
    b = (o == dio_pkg::CMD_SET_BIT) || (o == dio_pkg::CMD_WR_BIT && a != 0);
    if (o inside {dio_pkg::CMD_SET_BIT, dio_pkg::CMD_CLR_BIT, dio_pkg::CMD_WR_BIT}) begin
      if (n >= 1 && n <= 8) eo[n-1] = b;
      if (n >= 17 && n <= 80) ee[n-17] = b;
    end
    if (o == dio_pkg::CMD_WR_WORD) eo = a[7:0];
    // extended points in an output group read back their driven value
    if (o == dio_pkg::CMD_RD_BIT) eb = (n < 1 || n > 96) ? 1'b0 :
      (n >= 17 && n <= 80 && m[(n-17)/8]) ? ee[n-17] : sw[n-1];
    if (o == dio_pkg::CMD_RD_GROUP) eg = sw;
    q.push_back({eo, eb, eg});
    @(negedge clk);
  endtask : cmd
  always @(negedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      error_cnt++;
      results();
    end else if (rv === 1'b1) begin
      check({outp, rb, rg}, q.pop_front());
    end
  end
  initial begin
    sw = '0;
    op = dio_pkg::CMD_SET_BIT;
    num = 0;
    arg = 0;
    eo = 0;
    eb = 0;
    eg = 0;
    m = 0;
    ee = 0;
    void'($urandom(32702));
    repeat (5) @(negedge clk);
    arst_n = 1;
    check({24'h0, rdy, outp, oute, xe}, {24'h0, 1'b1, 80'h0});
    sw = {$urandom, $urandom, $urandom};
    repeat (3) @(negedge clk);
    cmd(dio_pkg::CMD_RD_GROUP, 0, 0, 0);
    for (int i = 0; i < 8; i++)
      cmd(dio_pkg::CMD_RD_BIT, i == 0 ? 96 : (i == 1 ? 97 : $urandom_range(1, 96)), 0, 0);
    for (int i = 0; i < 3; i++)
      cmd(dio_pkg::CMD_WR_WORD, 0, 0, i == 0 ? 32'hff : $urandom);
    for (int i = 0; i < 24; i++)
      cmd(dio_pkg::cmd_t'($urandom_range(0, 2)), $urandom_range(1, 8), 0,
        $urandom_range(0, 1) * $urandom);
    cmd(dio_pkg::CMD_SET_BIT, 9, 0, 0);
    vld = 0;
    @(negedge clk);
    check({97'h0, oute}, 105'h1);
    m = 8'($urandom) | 8'h01;
    cmd(dio_pkg::CMD_SET_DIR, 0, 0, {24'h0, m});
    vld = 0;
    repeat (3) @(negedge clk);
    for (int g = 0; g < 8; g++) x[g*8+:8] = {8{m[g]}};
    check({41'h0, xe}, {41'h0, x});
    cmd(dio_pkg::CMD_SET_BIT, 17, 0, 0);
    cmd(dio_pkg::CMD_RD_BIT, 17, 0, 0);
    for (int i = 0; i < 8; i++) begin
      p = $urandom_range(17, 80);
      cmd(dio_pkg::cmd_t'($urandom_range(0, 2)), p, 0, $urandom_range(0, 1) * $urandom);
      cmd(dio_pkg::CMD_RD_BIT, p, 0, 0);
    end
    vld = 0;
    @(negedge clk);
    check({41'h0, xo}, {41'h0, ee});
    for (int i = 0; i < 2; i++) begin
      sw[6-i] = i[0];
      // let the new level pass both synchroniser stages before the hold is taken
      repeat (3) @(negedge clk);
      cmd(dio_pkg::CMD_HOLD, 7 - i, i[0], 0);
      vld = 0;
      repeat (4) @(negedge clk);
      check({104'h0, rdy}, 105'h0);
      sw[6-i] = ~i[0];
      for (int k = 0; k < 10 && q.size() != 0; k++) @(negedge clk);
    end
    check(105'(q.size()), 105'h0);
    results();
  end
endmodule : testbench
